/* File: verilog/gripper_pkg.sv */
// Constants shared by the gripper command and status register block
package gripper_pkg;
  // Frame protocol values
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_PRESET_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [15:0] FIRST_WORD_ADDR = 16'h0000;
  localparam logic [15:0] WORD_COUNT = 16'h0003;
  localparam logic [15:0] PROTOCOL_ID = 16'h0000;
  localparam logic [7:0] DATA_BYTES = 8'h06;
  localparam logic [7:0] WRITE_ACK_LEN = 8'h06;
  localparam logic [7:0] READ_RESP_LEN = 8'h09;
  localparam logic [7:0] EXC_LEN = 8'h03;
  // Byte positions inside frames
  localparam logic [4:0] DATA_FIRST_IDX = 5'h0d;
  localparam logic [4:0] DATA_LAST_IDX = 5'h12;
  localparam logic [4:0] WRITE_REQ_LAST = 5'h12;
  localparam logic [4:0] READ_REQ_LAST = 5'h0b;
  localparam logic [4:0] WRITE_ACK_LAST = 5'h0b;
  localparam logic [4:0] READ_RESP_LAST = 5'h0e;
  localparam logic [4:0] EXC_LAST = 5'h08;
  localparam logic [4:0] STATUS_FIRST_IDX = 5'h09;
  localparam logic [4:0] IDX_MAX = 5'h1f;
  // Command and status field positions
  localparam int ACT_REQ_BIT = 8;
  localparam int GOTO_REQ_BIT = 11;
  // Object field codes and activation progress
  localparam logic [1:0] OBJ_MOVING = 2'h0;
  localparam logic [1:0] OBJ_OPEN_CONTACT = 2'h1;
  localparam logic [1:0] OBJ_CLOSE_CONTACT = 2'h2;
  localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
  localparam logic [1:0] STA_OFF = 2'h0;
  localparam logic [1:0] STA_BUSY = 2'h1;
  localparam logic [1:0] STA_DONE = 2'h3;
  // Finger figures
  localparam logic [7:0] SOFT_OPEN_LIMIT = 8'h0d;
  localparam logic [7:0] MECH_OPEN = 8'h00;
  localparam logic [7:0] MECH_CLOSE = 8'hff;
  localparam logic [7:0] MOVE_CURRENT = 8'h10;
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_NOT_ACTIVE = 8'h05;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Finger step time and its cycle count
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS = 20000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: verilog/motion_if.sv */
// Carrier between the register block and the finger motion unit
interface motion_if;
  logic act;
  logic goTo;
  logic [7:0] target;
  logic [7:0] speed;
  logic [7:0] forceLimit;
  logic cmdStrobe;
  logic contact;
  logic actState;
  logic gotoState;
  logic [1:0] staField;
  logic [1:0] objField;
  logic [7:0] position;
  logic [7:0] current;
  logic [7:0] fault;
  logic openingDrive;
  logic closingDrive;
  modport ctrl (
    output act, goTo, target, speed, forceLimit, cmdStrobe, contact,
    input actState, gotoState, staField, objField, position, current, fault,
    input openingDrive, closingDrive
  );
  modport unit (
    input act, goTo, target, speed, forceLimit, cmdStrobe, contact,
    output actState, gotoState, staField, objField, position, current, fault,
    output openingDrive, closingDrive
  );
endinterface

/* File: verilog/contact_sync.sv */
// Two-stage synchroniser for the object contact pin
module contact_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin and synchronised level
  input wire logic pinIn,
  output logic levelOut
);
  logic stage1_q;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1_q <= 1'b0;
      levelOut <= 1'b0;
    end
    else
    begin
      stage1_q <= pinIn;
      levelOut <= stage1_q;
    end
  end
endmodule

/* File: verilog/motion_unit.sv */
// Finger motion unit: activation routine, moves, contact and stop codes
module motion_unit #(
  parameter int STEP_CYCLES = gripper_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command and status carrier
  motion_if.unit m
);
  typedef enum logic [4:0] {
    M_OFF = 5'b00001,
    M_INIT_OPEN = 5'b00010,
    M_INIT_CLOSE = 5'b00100,
    M_IDLE = 5'b01000,
    M_MOVE = 5'b10000
  } mstate_e;

  mstate_e state_q;
  logic [15:0] stepCnt_q;
  logic [7:0] goal_q;
  logic tick;
  logic [7:0] clipped;

  // Step timer paces finger travel
  assign tick = (stepCnt_q == 16'(STEP_CYCLES - 1));
  always_ff @(posedge clk)
  begin
    if (reset || tick)
      stepCnt_q <= 16'h0000;
    else
      stepCnt_q <= stepCnt_q + 16'h0001;
  end

  // Full open is held at the software limit
  assign clipped = (m.target < gripper_pkg::SOFT_OPEN_LIMIT) ?
                   gripper_pkg::SOFT_OPEN_LIMIT : m.target;

  // Sequencer, position and object field
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= M_OFF;
      goal_q <= gripper_pkg::MECH_OPEN;
      m.position <= gripper_pkg::MECH_OPEN;
      m.objField <= gripper_pkg::OBJ_MOVING;
      m.staField <= gripper_pkg::STA_OFF;
      m.gotoState <= 1'b0;
      m.actState <= 1'b0;
    end
    else if (!m.act)
    begin
      state_q <= M_OFF;
      m.objField <= gripper_pkg::OBJ_MOVING;
      m.staField <= gripper_pkg::STA_OFF;
      m.gotoState <= 1'b0;
      m.actState <= 1'b0;
    end
    else
    begin
      m.actState <= 1'b1;
      if (m.cmdStrobe)
        m.gotoState <= m.goTo;
      case (state_q)
        M_OFF:
        begin
          state_q <= M_INIT_OPEN;
          m.staField <= gripper_pkg::STA_BUSY;
        end
        M_INIT_OPEN:
          if (tick)
          begin
            if (m.position == gripper_pkg::MECH_OPEN)
              state_q <= M_INIT_CLOSE;
            else
              m.position <= m.position - 8'h01;
          end
        M_INIT_CLOSE:
          if (tick)
          begin
            if (m.position == gripper_pkg::MECH_CLOSE)
            begin
              state_q <= M_IDLE;
              m.staField <= gripper_pkg::STA_DONE;
            end
            else
              m.position <= m.position + 8'h01;
          end
        M_IDLE, M_MOVE:
          if (m.cmdStrobe && m.goTo)
          begin
            state_q <= M_MOVE;
            goal_q <= clipped;
            m.objField <= gripper_pkg::OBJ_MOVING;
          end
          else if (state_q == M_MOVE && tick)
          begin
            if (m.position == goal_q)
            begin
              state_q <= M_IDLE;
              m.objField <= gripper_pkg::OBJ_AT_TARGET;
            end
            else if (m.contact)
            begin
              state_q <= M_IDLE;
              m.objField <= (goal_q > m.position) ?
                            gripper_pkg::OBJ_CLOSE_CONTACT :
                            gripper_pkg::OBJ_OPEN_CONTACT;
            end
            else if (goal_q > m.position)
              m.position <= m.position + 8'h01;
            else
              m.position <= m.position - 8'h01;
          end
        default:
          state_q <= M_OFF;
      endcase
    end
  end

  // Fault byte: motion asked for while not activated
  always_ff @(posedge clk)
  begin
    if (reset)
      m.fault <= gripper_pkg::FAULT_NONE;
    else if (m.cmdStrobe)
      m.fault <= (m.goTo && !m.act) ? gripper_pkg::FAULT_NOT_ACTIVE : gripper_pkg::FAULT_NONE;
  end

  // Motor current and drive levels follow travel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      m.current <= gripper_pkg::RESET_BYTE;
      m.openingDrive <= 1'b0;
      m.closingDrive <= 1'b0;
    end
    else
    begin
      m.current <= (state_q == M_IDLE || state_q == M_OFF) ?
                   gripper_pkg::RESET_BYTE : gripper_pkg::MOVE_CURRENT;
      m.openingDrive <= (state_q == M_INIT_OPEN) ||
                        (state_q == M_MOVE && goal_q < m.position);
      m.closingDrive <= (state_q == M_INIT_CLOSE) ||
                        (state_q == M_MOVE && goal_q > m.position);
    end
  end

  chk_at_target_code: assert property (@(posedge clk) disable iff (reset)
    (state_q == M_MOVE && tick && m.position == goal_q && m.act && !m.cmdStrobe)
    |=> (m.objField == gripper_pkg::OBJ_AT_TARGET && state_q == M_IDLE))
    else $error("target reached without object code three");
  chk_soft_limit: assert property (@(posedge clk) disable iff (reset)
    (state_q == M_MOVE) |-> (goal_q >= gripper_pkg::SOFT_OPEN_LIMIT))
    else $error("goal below software open limit");
  chk_close_contact: assert property (@(posedge clk) disable iff (reset)
    (state_q == M_MOVE && tick && m.act && !m.cmdStrobe && m.contact &&
     goal_q > m.position) |=> (m.objField == gripper_pkg::OBJ_CLOSE_CONTACT))
    else $error("closing contact not reported as code two");
  chk_init_start: assert property (@(posedge clk) disable iff (reset)
    (state_q == M_OFF && m.act) |=> (state_q == M_INIT_OPEN) ##1
    (m.staField == gripper_pkg::STA_BUSY || !m.act))
    else $error("activation did not start the routine");
  chk_move_current: assert property (@(posedge clk) disable iff (reset)
    (state_q == M_MOVE) ##1 (state_q == M_MOVE) |-> (m.current == gripper_pkg::MOVE_CURRENT))
    else $error("no motor current while moving");
endmodule

/* File: verilog/gripper_command_status_regs.sv */
// Register block: frame decode, command words, status words, replies
module gripper_command_status_regs #(
  parameter int STEP_CYCLES = gripper_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request frame bytes from the transport
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  output logic rxReady,
  // Reply frame bytes to the transport
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  // Finger hardware
  input wire logic contactPin,
  output logic openingDrive,
  output logic closingDrive
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DECIDE = 3'b010,
    ST_SEND = 3'b100
  } state_e;

  typedef enum logic [2:0] {
    K_WRITE = 3'b001,
    K_READ = 3'b010,
    K_EXC = 3'b100
  } kind_e;

  state_e state_q;
  kind_e kind_q;
  logic [4:0] rxIdx_q;
  logic [4:0] lastIdx_q;
  logic [4:0] txIdx_q;
  logic [4:0] dataOff;
  logic [15:0] tid_q;
  logic [15:0] pid_q;
  logic [7:0] unit_q;
  logic [7:0] fc_q;
  logic [15:0] addr_q;
  logic [15:0] qty_q;
  logic [7:0] bc_q;
  logic [7:0] excCode_q;
  logic [2:0][15:0] stage_q;
  logic [15:0] commandWordZero_q;
  logic [15:0] targetAndOptions_q;
  logic [15:0] motionLimits_q;
  logic [2:0][15:0] snap_q;
  logic strobe_q;
  logic [7:0] statusByte;
  logic rangeOk;
  logic writeOk;
  logic readOk;
  logic lastByte;
  logic txFire;

  motion_if m ();

  // Contact pin crosses into the clock domain
  contact_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pinIn(contactPin),
    .levelOut(m.contact)
  );

  motion_unit #(.STEP_CYCLES(STEP_CYCLES)) u_motion (
    .clk(clk),
    .reset(reset),
    .m(m.unit)
  );

  // Command words steer the motion unit; option bits are not used
  assign m.act = commandWordZero_q[gripper_pkg::ACT_REQ_BIT];
  assign m.goTo = commandWordZero_q[gripper_pkg::GOTO_REQ_BIT];
  assign m.target = targetAndOptions_q[7:0];
  assign m.speed = motionLimits_q[15:8];
  assign m.forceLimit = motionLimits_q[7:0];
  assign m.cmdStrobe = strobe_q;
  assign openingDrive = m.openingDrive;
  assign closingDrive = m.closingDrive;

  // Status byte from motion state
  assign statusByte = {m.objField, m.staField, m.gotoState, 2'b00, m.actState};

  // Request checks
  assign dataOff = rxIdx_q - gripper_pkg::DATA_FIRST_IDX;
  assign rangeOk = (addr_q == gripper_pkg::FIRST_WORD_ADDR) && (qty_q == gripper_pkg::WORD_COUNT);
  assign writeOk = rangeOk && (bc_q == gripper_pkg::DATA_BYTES) &&
                   (lastIdx_q == gripper_pkg::WRITE_REQ_LAST);
  assign readOk = rangeOk && (lastIdx_q == gripper_pkg::READ_REQ_LAST);

  // Reply byte at a given position
  function automatic logic [7:0] respByte(input logic [4:0] idx);
    logic [4:0] off;
    logic [15:0] word;
    off = idx - gripper_pkg::STATUS_FIRST_IDX;
    word = snap_q[off[2:1]];
    case (idx)
      5'h00: respByte = tid_q[15:8];
      5'h01: respByte = tid_q[7:0];
      5'h02: respByte = gripper_pkg::PROTOCOL_ID[15:8];
      5'h03: respByte = gripper_pkg::PROTOCOL_ID[7:0];
      5'h04: respByte = 8'h00;
      5'h05: respByte = (kind_q == K_WRITE) ? gripper_pkg::WRITE_ACK_LEN :
                        (kind_q == K_READ) ? gripper_pkg::READ_RESP_LEN : gripper_pkg::EXC_LEN;
      5'h06: respByte = unit_q;
      5'h07: respByte = (kind_q == K_EXC) ? (fc_q | gripper_pkg::EXC_FLAG) : fc_q;
      5'h08: respByte = (kind_q == K_WRITE) ? gripper_pkg::FIRST_WORD_ADDR[15:8] :
                        (kind_q == K_READ) ? gripper_pkg::DATA_BYTES : excCode_q;
      default:
        if (kind_q == K_WRITE)
        begin
          case (idx)
            5'h09: respByte = gripper_pkg::FIRST_WORD_ADDR[7:0];
            5'h0a: respByte = gripper_pkg::WORD_COUNT[15:8];
            default: respByte = gripper_pkg::WORD_COUNT[7:0];
          endcase
        end
        else
          respByte = off[0] ? word[7:0] : word[15:8];
    endcase
  endfunction

  // Request header and data capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tid_q <= gripper_pkg::RESET_WORD;
      pid_q <= gripper_pkg::RESET_WORD;
      unit_q <= gripper_pkg::RESET_BYTE;
      fc_q <= gripper_pkg::RESET_BYTE;
      addr_q <= gripper_pkg::RESET_WORD;
      qty_q <= gripper_pkg::RESET_WORD;
      bc_q <= gripper_pkg::RESET_BYTE;
      stage_q <= '0;
    end
    else if (state_q == ST_IDLE && rxValid)
    begin
      case (rxIdx_q)
        5'h00: tid_q[15:8] <= rxData;
        5'h01: tid_q[7:0] <= rxData;
        5'h02: pid_q[15:8] <= rxData;
        5'h03: pid_q[7:0] <= rxData;
        5'h06: unit_q <= rxData;
        5'h07: fc_q <= rxData;
        5'h08: addr_q[15:8] <= rxData;
        5'h09: addr_q[7:0] <= rxData;
        5'h0a: qty_q[15:8] <= rxData;
        5'h0b: qty_q[7:0] <= rxData;
        5'h0c: bc_q <= rxData;
        default:
          if (rxIdx_q >= gripper_pkg::DATA_FIRST_IDX && rxIdx_q <= gripper_pkg::DATA_LAST_IDX)
          begin
            if (dataOff[0])
              stage_q[dataOff[2:1]][7:0] <= rxData;
            else
              stage_q[dataOff[2:1]][15:8] <= rxData;
          end
      endcase
    end
  end

  // Byte counter and frame length
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxIdx_q <= 5'h00;
      lastIdx_q <= 5'h00;
    end
    else if (state_q == ST_IDLE && rxValid)
    begin
      if (rxEnd)
      begin
        rxIdx_q <= 5'h00;
        lastIdx_q <= rxIdx_q;
      end
      else if (rxIdx_q != gripper_pkg::IDX_MAX)
        rxIdx_q <= rxIdx_q + 5'h01;
    end
  end

  // Command words: written only by a whole three-word write
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      commandWordZero_q <= gripper_pkg::RESET_WORD;
      targetAndOptions_q <= gripper_pkg::RESET_WORD;
      motionLimits_q <= gripper_pkg::RESET_WORD;
      strobe_q <= 1'b0;
    end
    else
    begin
      strobe_q <= 1'b0;
      if (state_q == ST_DECIDE && fc_q == gripper_pkg::FC_PRESET_MULTI && writeOk &&
          pid_q == gripper_pkg::PROTOCOL_ID)
      begin
        commandWordZero_q <= stage_q[0];
        targetAndOptions_q <= stage_q[1];
        motionLimits_q <= stage_q[2];
        strobe_q <= 1'b1;
      end
    end
  end

  // Status snapshot, separate from the command words
  always_ff @(posedge clk)
  begin
    if (reset)
      snap_q <= '0;
    else if (state_q == ST_DECIDE && fc_q == gripper_pkg::FC_READ_INPUT && readOk)
    begin
      snap_q[0] <= {statusByte, gripper_pkg::RESET_BYTE};
      snap_q[1] <= {m.fault, targetAndOptions_q[7:0]};
      snap_q[2] <= {m.position, m.current};
    end
  end

  // Frame sequencer and reply stream
  assign lastByte = (kind_q == K_WRITE) ? (txIdx_q == gripper_pkg::WRITE_ACK_LAST) :
                    (kind_q == K_READ) ? (txIdx_q == gripper_pkg::READ_RESP_LAST) :
                    (txIdx_q == gripper_pkg::EXC_LAST);
  assign txFire = txValid && txReady;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      kind_q <= K_EXC;
      excCode_q <= gripper_pkg::RESET_BYTE;
      txIdx_q <= 5'h00;
      rxReady <= 1'b1;
      txValid <= 1'b0;
      txData <= gripper_pkg::RESET_BYTE;
      txLast <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (rxValid && rxEnd)
          begin
            state_q <= ST_DECIDE;
            rxReady <= 1'b0;
          end
        ST_DECIDE:
        begin
          txIdx_q <= 5'h00;
          if (pid_q != gripper_pkg::PROTOCOL_ID)
          begin
            state_q <= ST_IDLE;
            rxReady <= 1'b1;
          end
          else
          begin
            state_q <= ST_SEND;
            txValid <= 1'b1;
            txData <= tid_q[15:8];
            txLast <= 1'b0;
            if (fc_q == gripper_pkg::FC_PRESET_MULTI && writeOk)
              kind_q <= K_WRITE;
            else if (fc_q == gripper_pkg::FC_READ_INPUT && readOk)
              kind_q <= K_READ;
            else
            begin
              kind_q <= K_EXC;
              excCode_q <= (fc_q == gripper_pkg::FC_PRESET_MULTI ||
                            fc_q == gripper_pkg::FC_READ_INPUT) ?
                           gripper_pkg::EXC_ILLEGAL_ADDR : gripper_pkg::EXC_ILLEGAL_FUNC;
            end
          end
        end
        ST_SEND:
          if (txFire)
          begin
            if (txLast)
            begin
              state_q <= ST_IDLE;
              txValid <= 1'b0;
              txLast <= 1'b0;
              rxReady <= 1'b1;
            end
            else
            begin
              txIdx_q <= txIdx_q + 5'h01;
              txData <= respByte(txIdx_q + 5'h01);
              txLast <= (kind_q == K_WRITE) ? (txIdx_q + 5'h01 == gripper_pkg::WRITE_ACK_LAST) :
                        (kind_q == K_READ) ? (txIdx_q + 5'h01 == gripper_pkg::READ_RESP_LAST) :
                        (txIdx_q + 5'h01 == gripper_pkg::EXC_LAST);
            end
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  chk_ack_length: assert property (@(posedge clk) disable iff (reset)
    (txValid && kind_q == K_WRITE && txIdx_q == 5'h05) |-> (txData == 8'h06))
    else $error("write reply length byte not six");
  chk_read_count: assert property (@(posedge clk) disable iff (reset)
    (txValid && kind_q == K_READ && txIdx_q == 5'h08) |-> (txData == 8'h06))
    else $error("read reply byte count not six");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (txValid && kind_q == K_READ && txIdx_q == 5'h0a) |-> (txData == 8'h00))
    else $error("reserved status byte not zero");
  chk_cmd_latch: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_DECIDE && fc_q == 8'h10 && writeOk && pid_q == 16'h0000)
    |=> (commandWordZero_q == $past(stage_q[0]) && strobe_q) ##1 !strobe_q)
    else $error("command word not taken from write");
  chk_status_source: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_DECIDE && fc_q == 8'h04 && readOk)
    |=> (snap_q[0][15:8] == $past(statusByte) && snap_q[1][7:0] == targetAndOptions_q[7:0]))
    else $error("status read not taken from device state");
  chk_tx_hold: assert property (@(posedge clk) disable iff (reset)
    (txValid && !txReady) |=> (txValid && $stable(txData) && $stable(txLast)))
    else $error("reply byte dropped under back-pressure");
  chk_reply_end: assert property (@(posedge clk) disable iff (reset)
    (txValid && kind_q == K_WRITE && txLast) |-> (txIdx_q == 5'h0b))
    else $error("write reply not twelve bytes");
endmodule

/* File: verif/modbus_client_model.sv */
// Controller-side model: sends request frames and gathers reply bytes
module modbus_client_model (
  // Clock
  input wire logic clk,
  // Request stream
  output logic rxValid = 1'b0,
  output logic [7:0] rxData = 8'h00,
  output logic rxEnd = 1'b0,
  input wire logic rxReady,
  // Reply stream
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] reply [0:31];
  int replyLen = 0;

  // Offer each byte until taken, then collect the reply, stalling if slow
  task automatic xfer(input logic [7:0] req [$], input bit slow);
    int i;
    int w;
    i = 0;
    w = 0;
    replyLen = 0;
    while (i < req.size() && w < 400)
    begin
      rxValid <= 1'b1;
      rxData <= req[i];
      rxEnd <= (i == req.size() - 1);
      @(posedge clk);
      w++;
      if (rxReady === 1'b1)
        i++;
    end
    // Released line shows no stale byte
    rxValid <= 1'b0;
    rxData <= ~rxData;
    rxEnd <= 1'b0;
    while (w < 800)
    begin
      txReady <= slow ? ~txReady : 1'b1;
      @(posedge clk);
      w++;
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
        reply[replyLen] = txData;
        replyLen++;
        if (txLast === 1'b1)
          break;
      end
    end
    txReady <= 1'b0;
  endtask
endmodule

/* File: verif/gripper_command_status_regs_bench.sv */
// Self-checking bench for the gripper register block
module gripper_command_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEPS = 2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic contactPin = 1'b0;
  logic rxValid, rxEnd, rxReady, txValid, txLast, txReady, openingDrive, closingDrive;
  logic [7:0] rxData, txData;
  logic [7:0] q [$];
  logic [15:0] st [3];
  int errors = 0;
  int tests_run = 0;

  // Clock
  always #20 clk = ~clk;

  gripper_command_status_regs #(.STEP_CYCLES(STEPS)) dut_u (.clk(clk), .reset(reset),
    .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
    .contactPin(contactPin), .openingDrive(openingDrive), .closingDrive(closingDrive));

  modbus_client_model client_u (.clk(clk), .rxValid(rxValid), .rxData(rxData),
    .rxEnd(rxEnd), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady));

  // Compare one value
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write three command words, check the echoed reply
  task automatic wr(input logic [15:0] w0, input logic [15:0] w1);
    q = '{8'h34, 8'hab, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h03,
      8'h06, w0[15:8], w0[7:0], w1[15:8], w1[7:0], 8'hff, 8'hff};
    client_u.xfer(q, 1'b1);
    check(16'(client_u.replyLen), 16'h000c);
    for (int i = 0; i < 12; i++)
      check({8'h00, client_u.reply[i]}, {8'h00, q[i] ^ (i == 5 ? 8'h0b : 8'h00)});
  endtask

  // Read the three status words, high byte first
  task automatic rd();
    q = '{8'hd6, 8'h05, 8'h00, 8'h00, 8'h00, 8'h06, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h03};
    client_u.xfer(q, 1'b0);
    check(16'(client_u.replyLen), 16'h000f);
    check({client_u.reply[5], client_u.reply[8]}, 16'h0906);
    for (int i = 0; i < 3; i++)
      st[i] = {client_u.reply[9 + 2 * i], client_u.reply[10 + 2 * i]};
  endtask

  // Poll status until the wanted word shows, bounded
  task automatic poll(input logic [15:0] want);
    int n;
    n = 0;
    rd();
    while (st[0] !== want && n < 80)
    begin
      rd();
      n++;
    end
    check(st[0], want);
  endtask

  // Activate alone: busy, then done and closed
  task automatic t_activate();
    wr(16'h0100, 16'h0000);
    rd();
    check(st[0], 16'h1100);
    poll(16'h3100);
    check(st[2], 16'hff00);
  endtask

  // Full open: moving, then stop at the soft limit
  task automatic t_open();
    wr(16'h0900, 16'h0000);
    rd();
    check(st[0], 16'h3900);
    check({8'h00, st[2][7:0]}, 16'h0010);
    check({15'h0000, openingDrive}, 16'h0001);
    poll(16'hf900);
    check({14'h0000, openingDrive, closingDrive}, 16'h0000);
    check(st[1], 16'h0000);
    check(st[2], 16'h0d00);
  endtask

  // Close with option bits set, finger contact midway
  task automatic t_close();
    wr(16'h09a5, 16'h5aff);
    rd();
    check(st[1], 16'h00ff);
    check({8'h00, st[0][7:0]}, 16'h0000);
    check({15'h0000, closingDrive}, 16'h0001);
    repeat (40) @(posedge clk);
    contactPin <= 1'b1;
    poll(16'hb900);
    contactPin <= 1'b0;
  endtask

  // Refused read range, then a move asked for while not activated
  task automatic t_refuse();
    q = '{8'hd6, 8'h05, 8'h00, 8'h00, 8'h00, 8'h06, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03};
    client_u.xfer(q, 1'b0);
    check(16'(client_u.replyLen), 16'h0009);
    check({client_u.reply[7], client_u.reply[8]}, 16'h8402);
    wr(16'h0800, 16'h0000);
    rd();
    check(st[0], 16'h0000);
    check(st[1], 16'h0500);
  endtask

  // Report counts and verdict, then stop
  task automatic tally_and_finish();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_activate();
    t_open();
    t_close();
    t_refuse();
    tally_and_finish();
  end

  // Watchdog
  initial
  begin
    #800us;
    errors++;
    tally_and_finish();
  end
endmodule
